//--- src/frmc_top.sv
// Purpose: flash rewrite mode control: mode select, area limits, locks
// Assumes: pins sampled synchronously; straps captured at reset release
// Notes: control bits are plain ports; one request per cycle
`timescale 1ns/1ps
`include "frmc_cfg.svh"

module frmc_top
  import frmc_pkg::*;
#(
  parameter int NUM_BLOCKS = `FRMC_NUM_BLOCKS,
  parameter int ADDR_W = `FRMC_ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Strap pins, caught at reset release
  input wire logic processor_mode_pin,
  input wire logic first_boot_select_pin,
  input wire logic second_boot_select_pin,
  input wire logic parallel_strap,
  input wire logic expand_mode,
  // Programmer attach
  input wire logic serial_attach,
  input wire logic serial_uart,
  // Mode register bits from software
  input wire logic cpu_rewrite_enable_wr,
  input wire logic cpu_rewrite_enable_bit,
  input wire logic in_place_erase_write_mode,
  input wire logic pm1_wr,
  input wire logic block_a_enable_wdata,
  input wire logic extended_area_enable_wdata,
  // Commands
  input wire frmc_req_t req,
  input wire logic lock_wr,
  input wire logic [NUM_BLOCKS-1:0] lock_wdata,
  // Address check
  input wire logic [ADDR_W-1:0] addr,
  input wire logic mode_4m,
  // Status
  output frmc_mode_t mode_reg,
  output frmc_chip_t chip_reg,
  output logic serial_variant2_reg,
  output logic cpu_rewrite_active_reg,
  output logic block_a_enable_bit,
  output logic extended_area_enable_bit,
  output logic [NUM_BLOCKS-1:0] lock_reg,
  output frmc_grant_t grant_reg,
  output logic ext_blocked_reg
);

  // ****************************************
  // Strap capture and chip mode
  // ****************************************
  logic strap_done_reg;
  frmc_chip_t chip_next;
  wire logic boot_strap;

  assign boot_strap = processor_mode_pin && first_boot_select_pin && !second_boot_select_pin;
  always_comb begin
    if (parallel_strap) begin
      chip_next = FRMC_CHIP_PARALLEL;
    end else if (boot_strap) begin
      chip_next = FRMC_CHIP_BOOT;
    end else if (expand_mode) begin
      chip_next = FRMC_CHIP_EXPAND;
    end else begin
      chip_next = FRMC_CHIP_SINGLE;
    end
  end

  // Straps latched once after release; async reset may only load constants
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      chip_reg <= FRMC_CHIP_SINGLE;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      chip_reg <= chip_next;
    end
  end

  // ****************************************
  // Rewrite mode selection
  // ****************************************
  frmc_mode_t mode_next;
  wire logic cpu_allowed;
  wire logic cpu_req_ok;
  wire logic cpu_keep;

  // Clear write drops CPU mode on the same edge as the enable flag
  assign cpu_keep = cpu_rewrite_active_reg && !(cpu_rewrite_enable_wr && !cpu_rewrite_enable_bit);
  // Expansion and boot only permit the RAM-resident flavour
  assign cpu_allowed = (chip_reg == FRMC_CHIP_SINGLE) ||
                       (((chip_reg == FRMC_CHIP_EXPAND) || (chip_reg == FRMC_CHIP_BOOT)) &&
                        !in_place_erase_write_mode);
  assign cpu_req_ok = cpu_rewrite_enable_wr && cpu_rewrite_enable_bit && cpu_allowed;

  always_comb begin
    case (chip_reg)
      FRMC_CHIP_PARALLEL: mode_next = FRMC_MODE_PARALLEL;
      FRMC_CHIP_BOOT: begin
        if (serial_attach) begin
          mode_next = FRMC_MODE_SERIAL;
        end else if (cpu_keep || cpu_req_ok) begin
          mode_next = FRMC_MODE_CPU;
        end else begin
          mode_next = FRMC_MODE_NONE;
        end
      end
      default: begin
        if (cpu_keep || cpu_req_ok) begin
          mode_next = FRMC_MODE_CPU;
        end else begin
          mode_next = FRMC_MODE_NONE;
        end
      end
    endcase
  end

  // ****************************************
  // CPU rewrite enable and memory-area bits
  // ****************************************
  logic cpu_next;
  logic block_a_reg;
  logic ext_saved_reg;
  logic ext_saved_next;
  logic block_a_next;
  wire logic cpu_clear;

  assign cpu_clear = cpu_rewrite_enable_wr && !cpu_rewrite_enable_bit;
  always_comb begin
    cpu_next = cpu_rewrite_active_reg;
    if (cpu_clear) begin
      cpu_next = 1'b0;
    end else if (cpu_req_ok && mode_next == FRMC_MODE_CPU) begin
      cpu_next = 1'b1;
    end
  end

  // Software value kept aside; pending writes land here during rewrite
  always_comb begin
    ext_saved_next = ext_saved_reg;
    block_a_next = block_a_reg;
    if (pm1_wr) begin
      ext_saved_next = extended_area_enable_wdata;
      block_a_next = block_a_enable_wdata;
    end
    if (cpu_next && !cpu_rewrite_active_reg) begin
      block_a_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= FRMC_MODE_NONE;
      cpu_rewrite_active_reg <= 1'b0;
      ext_saved_reg <= 1'b0;
      block_a_reg <= 1'b0;
      serial_variant2_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      cpu_rewrite_active_reg <= cpu_next;
      ext_saved_reg <= ext_saved_next;
      block_a_reg <= block_a_next;
      serial_variant2_reg <= serial_uart;
    end
  end

  // Forced view; the saved value comes back as soon as rewrite ends
  assign extended_area_enable_bit = cpu_rewrite_active_reg ? 1'b1 : ext_saved_reg;
  assign block_a_enable_bit = block_a_reg;

  // ****************************************
  // Lock bits
  // ****************************************
  logic [NUM_BLOCKS-1:0] lock_next;
  wire logic cmd_is_lock;

  assign cmd_is_lock = req.valid && (req.cmd == FRMC_CMD_LOCK_BLOCK) && (mode_reg != FRMC_MODE_NONE);
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BLOCKS; gi++) begin : g_lock
      // Lock bit is 0 when locked, as in protect-by-clear
      assign lock_next[gi] = lock_wr ? lock_wdata[gi] :
                             (cmd_is_lock && req.block == 3'(gi)) ? 1'b0 : lock_reg[gi];
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_reg <= NUM_BLOCKS'(`FRMC_LOCK_RST);
    end else begin
      lock_reg <= lock_next;
    end
  end

  // ****************************************
  // Command acceptance
  // ****************************************
  frmc_grant_t grant_next;
  wire logic is_prog;
  wire logic is_berase;
  wire logic is_eall;
  wire logic target_locked;
  wire logic area_ok;
  wire logic unit_ok;
  wire logic [NUM_BLOCKS-1:0] onehot_blk;

  assign is_prog = req.cmd == FRMC_CMD_PROGRAM;
  assign is_berase = req.cmd == FRMC_CMD_BLOCK_ERASE;
  assign is_eall = req.cmd == FRMC_CMD_ERASE_ALL;
  assign target_locked = !lock_reg[req.block];
  // Boot ROM is a single block reachable only from the parallel programmer
  assign area_ok = !req.boot_area || (mode_reg == FRMC_MODE_PARALLEL);
  assign unit_ok = !req.byte_unit || (mode_reg == FRMC_MODE_PARALLEL) || !is_prog;
  assign onehot_blk = NUM_BLOCKS'(1) << req.block;

  always_comb begin
    grant_next = '0;
    if (req.valid && mode_reg != FRMC_MODE_NONE && (is_prog || is_berase || is_eall)) begin
      if (!area_ok || !unit_ok || (!is_eall && !req.boot_area && target_locked)) begin
        grant_next.rejected = 1'b1;
      end else begin
        grant_next.accepted = 1'b1;
        grant_next.erase_all = is_eall;
        // Erase-all skips locked blocks
        grant_next.block_sel = 8'(is_eall ? lock_reg : (req.boot_area ? '0 : onehot_blk));
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grant_reg <= '0;
    end else begin
      grant_reg <= grant_next;
    end
  end

  // ****************************************
  // Extended area gate
  // ****************************************
  frmc_area_gate #(
    .ADDR_W(ADDR_W)
  ) u_gate (
    .clk(clk),
    .rst(rst),
    .addr(addr),
    .mode_4m(mode_4m),
    .ext_en(extended_area_enable_bit),
    .ext_blocked_reg(ext_blocked_reg)
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence s_cpu_on;
    cpu_rewrite_active_reg;
  endsequence

  chk_ext_forced_high: assert property (@(posedge clk) disable iff (rst)
    s_cpu_on |-> extended_area_enable_bit)
    else $error("extended enable not forced");
  chk_ext_restore_value: assert property (@(posedge clk) disable iff (rst)
    ($fell(cpu_rewrite_active_reg) && !$past(pm1_wr)) |-> extended_area_enable_bit == $past(ext_saved_reg))
    else $error("extended enable not restored");
  chk_ext_write_pending: assert property (@(posedge clk) disable iff (rst)
    (cpu_rewrite_active_reg && pm1_wr && !cpu_clear) |=> extended_area_enable_bit)
    else $error("pending write leaked");
  chk_block_a_set: assert property (@(posedge clk) disable iff (rst)
    $rose(cpu_rewrite_active_reg) |-> block_a_enable_bit)
    else $error("block A not enabled");
  chk_boot_parallel_only: assert property (@(posedge clk) disable iff (rst)
    (req.valid && req.boot_area && mode_reg != FRMC_MODE_PARALLEL) |=> !grant_reg.accepted)
    else $error("boot ROM rewrite outside parallel");
  chk_byte_parallel_only: assert property (@(posedge clk) disable iff (rst)
    (req.valid && is_prog && req.byte_unit && mode_reg != FRMC_MODE_PARALLEL) |=> grant_reg.rejected)
    else $error("byte program outside parallel");
  chk_locked_refused: assert property (@(posedge clk) disable iff (rst)
    (req.valid && (is_prog || is_berase) && !req.boot_area && target_locked) |=> !grant_reg.accepted)
    else $error("locked block altered");
  chk_serial_boot_only: assert property (@(posedge clk) disable iff (rst)
    (mode_reg == FRMC_MODE_SERIAL) |-> chip_reg == FRMC_CHIP_BOOT)
    else $error("serial mode outside boot");
  chk_boot_strap_entry: assert property (@(posedge clk) disable iff (rst)
    (!strap_done_reg && boot_strap && !parallel_strap) |=> chip_reg == FRMC_CHIP_BOOT)
    else $error("boot mode not entered");
  chk_erase_whole: assert property (@(posedge clk) disable iff (rst)
    (req.valid && is_eall && mode_reg != FRMC_MODE_NONE && unit_ok && area_ok) |=> grant_reg.erase_all)
    else $error("erase all not granted");

endmodule : frmc_top

//--- src/frmc_cfg.svh
// Purpose: constants for the flash rewrite mode control block
// Assumes: byte addresses on a 20-bit address space
// Notes: range limits, sizes, widths and the lock reset value live here
`ifndef FRMC_CFG_SVH
`define FRMC_CFG_SVH

`define FRMC_ADDR_W 20
`define FRMC_NUM_BLOCKS 8
`define FRMC_BLK_W 3
`define FRMC_BOOT_BLOCK_BYTES 4096
`define FRMC_EXT_LO 20'h40000
`define FRMC_EXT_HI 20'hBFFFF
`define FRMC_CMD_W 3
`define FRMC_NUM_CMDS 8
`define FRMC_LOCK_RST 8'hFF

`endif

//--- src/frmc_pkg.sv
// Purpose: shared types for the flash rewrite mode control block
// Assumes: widths are written as literals that match frmc_cfg.svh
// Notes: types only
`include "frmc_cfg.svh"

package frmc_pkg;

  typedef enum logic [1:0] {
    FRMC_MODE_NONE = 2'h0,
    FRMC_MODE_CPU = 2'h1,
    FRMC_MODE_SERIAL = 2'h2,
    FRMC_MODE_PARALLEL = 2'h3
  } frmc_mode_t;

  typedef enum logic [1:0] {
    FRMC_CHIP_SINGLE = 2'h0,
    FRMC_CHIP_EXPAND = 2'h1,
    FRMC_CHIP_BOOT = 2'h2,
    FRMC_CHIP_PARALLEL = 2'h3
  } frmc_chip_t;

  typedef enum logic [2:0] {
    FRMC_CMD_READ_ARRAY = 3'h0,
    FRMC_CMD_READ_STATUS = 3'h1,
    FRMC_CMD_CLEAR_STATUS = 3'h2,
    FRMC_CMD_PROGRAM = 3'h3,
    FRMC_CMD_BLOCK_ERASE = 3'h4,
    FRMC_CMD_ERASE_ALL = 3'h5,
    FRMC_CMD_LOCK_BLOCK = 3'h6,
    FRMC_CMD_READ_LOCK = 3'h7
  } frmc_cmd_t;

  typedef struct packed {
    logic valid;
    frmc_cmd_t cmd;
    logic [2:0] block;
    logic boot_area;
    logic byte_unit;
  } frmc_req_t;

  typedef struct packed {
    logic accepted;
    logic rejected;
    logic erase_all;
    logic [7:0] block_sel;
  } frmc_grant_t;

endpackage : frmc_pkg

//--- src/frmc_area_gate.sv
// Purpose: gate the extended address range on the extended-area enable
// Assumes: byte addresses, synchronous inputs
// Notes: combinational decode, registered result
`timescale 1ns/1ps
`include "frmc_cfg.svh"

module frmc_area_gate
  import frmc_pkg::*;
#(
  parameter int ADDR_W = `FRMC_ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access
  input wire logic [ADDR_W-1:0] addr,
  input wire logic mode_4m,
  input wire logic ext_en,
  // Result
  output logic ext_blocked_reg
);

  wire logic in_ext;
  wire logic blocked_next;

  assign in_ext = (addr >= ADDR_W'(`FRMC_EXT_LO)) && (addr <= ADDR_W'(`FRMC_EXT_HI));
  assign blocked_next = in_ext && mode_4m && !ext_en;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_blocked_reg <= 1'b0;
    end else begin
      ext_blocked_reg <= blocked_next;
    end
  end

  chk_ext_gap_blocked: assert property (@(posedge clk) disable iff (rst)
    (in_ext && mode_4m && !ext_en) |=> ext_blocked_reg)
    else $error("extended range not blocked");

endmodule : frmc_area_gate

//--- testbench/frmc_sw_model.sv
// Purpose: software side that issues flash commands to the block
// Assumes: bench calls issue only after reset has settled
// Notes: each request is valid for exactly one cycle
`timescale 1ns/1ps

module frmc_sw_model
  import frmc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command out
  output frmc_req_t req
);
  // ****************************************
  // Command issue
  // ****************************************
  initial req = '0;

  // Control program sits in RAM, so no fetch hits flash here
  task automatic issue(input frmc_cmd_t c, input logic [2:0] b, input logic boot, input logic byt);
    @(posedge clk);
    req <= '{valid: 1'b1, cmd: c, block: b, boot_area: boot, byte_unit: byt};
    @(posedge clk);
    req <= '0;
  endtask : issue
endmodule : frmc_sw_model

//--- testbench/frmc_top_test.sv
// Purpose: self-checking bench for the rewrite mode control block
// Assumes: straps are held steady across reset release
// Notes: each scenario task drives and judges on its own
`timescale 1ns/1ps

module frmc_top_test
  import frmc_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 0, rst = 1, pm_pin = 0, bs1 = 0, bs2 = 0, par = 0, expm = 0;
  logic s_att = 0, s_uart = 0, cw = 0, cb = 0, inpl = 0, pw = 0, pa = 0, pe = 0;
  logic lw = 0, m4 = 0, var2, cact, blka, exte, blkd;
  logic [7:0] lwd = 8'hFF;
  logic [7:0] lock;
  logic [19:0] addr = 20'h00000;
  frmc_req_t req;
  frmc_mode_t mode;
  frmc_chip_t chip;
  frmc_grant_t gnt;
  int fail_count = 0, compares = 0;

  always #2.5 clk = ~clk;

  frmc_sw_model i_frmc_sw_model (.clk(clk), .req(req));

  frmc_top i_frmc_top (
    .clk(clk), .rst(rst), .processor_mode_pin(pm_pin), .first_boot_select_pin(bs1),
    .second_boot_select_pin(bs2), .parallel_strap(par), .expand_mode(expm),
    .serial_attach(s_att), .serial_uart(s_uart), .cpu_rewrite_enable_wr(cw),
    .cpu_rewrite_enable_bit(cb), .in_place_erase_write_mode(inpl), .pm1_wr(pw),
    .block_a_enable_wdata(pa), .extended_area_enable_wdata(pe), .req(req),
    .lock_wr(lw), .lock_wdata(lwd), .addr(addr), .mode_4m(m4), .mode_reg(mode),
    .chip_reg(chip), .serial_variant2_reg(var2), .cpu_rewrite_active_reg(cact),
    .block_a_enable_bit(blka), .extended_area_enable_bit(exte), .lock_reg(lock),
    .grant_reg(gnt), .ext_blocked_reg(blkd)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // Straps order: processor mode, boot 1, boot 2, parallel, expansion
  task automatic do_reset(input logic [4:0] s);
    @(posedge clk);
    {pm_pin, bs1, bs2, par, expm} <= s;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_reset

  task automatic wr_cpu(input logic v, input logic ip);
    @(posedge clk);
    cw <= 1'b1;
    cb <= v;
    inpl <= ip;
    @(posedge clk);
    cw <= 1'b0;
    #1;
  endtask : wr_cpu

  task automatic wr_pm1(input logic a, input logic e);
    @(posedge clk);
    pw <= 1'b1;
    pa <= a;
    pe <= e;
    @(posedge clk);
    pw <= 1'b0;
    #1;
  endtask : wr_pm1

  task automatic cmd(input frmc_cmd_t c, input logic [2:0] b, input logic bt, input logic by);
    i_frmc_sw_model.issue(c, b, bt, by);
    #1;
  endtask : cmd

  task automatic area(input logic [19:0] a, input logic m, input logic e);
    @(posedge clk);
    addr <= a;
    m4 <= m;
    @(posedge clk);
    #1;
    chk("ext_blocked", e, blkd);
  endtask : area

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    do_reset(5'b00000);
    chk("lock", 8'hFF, lock);
    chk("grant", 0, gnt);
    chk("chip", FRMC_CHIP_SINGLE, chip);
    chk("mode", FRMC_MODE_NONE, mode);
    chk("ext_en", 0, exte);
  endtask : t_reset

  task automatic t_cpu;
    wr_pm1(1'b0, 1'b0);
    wr_cpu(1'b1, 1'b1);
    chk("cpu_act", 1, cact);
    chk("mode", FRMC_MODE_CPU, mode);
    chk("blk_a", 1, blka);
    chk("ext_en", 1, exte);
    wr_pm1(1'b0, 1'b1);
    chk("ext_en", 1, exte);
    wr_cpu(1'b0, 1'b1);
    chk("ext_en", 1, exte);
    wr_pm1(1'b0, 1'b0);
    wr_cpu(1'b1, 1'b0);
    chk("ext_en", 1, exte);
    wr_cpu(1'b0, 1'b0);
    chk("ext_en", 0, exte);
    chk("mode", FRMC_MODE_NONE, mode);
  endtask : t_cpu

  task automatic t_cmds;
    wr_cpu(1'b1, 1'b0);
    cmd(FRMC_CMD_PROGRAM, 3'h2, 1'b0, 1'b0);
    chk("grant", 11'h404, gnt);
    @(posedge clk);
    #1;
    chk("grant", 0, gnt);
    cmd(FRMC_CMD_PROGRAM, 3'h2, 1'b0, 1'b1);
    chk("grant", 2'b01, gnt[10:9]);
    cmd(FRMC_CMD_BLOCK_ERASE, 3'h0, 1'b1, 1'b0);
    chk("grant", 2'b01, gnt[10:9]);
    cmd(FRMC_CMD_BLOCK_ERASE, 3'h7, 1'b0, 1'b0);
    chk("grant", 11'h480, gnt);
    cmd(FRMC_CMD_LOCK_BLOCK, 3'h5, 1'b0, 1'b0);
    chk("lock", 8'hDF, lock);
    cmd(FRMC_CMD_PROGRAM, 3'h5, 1'b0, 1'b0);
    chk("grant", 2'b01, gnt[10:9]);
    cmd(FRMC_CMD_BLOCK_ERASE, 3'h5, 1'b0, 1'b0);
    chk("grant", 2'b01, gnt[10:9]);
    cmd(FRMC_CMD_ERASE_ALL, 3'h0, 1'b0, 1'b0);
    chk("grant", 11'h5DF, gnt);
    for (int i = 0; i < 8; i++) begin
      if (!(i inside {3, 4, 5, 6})) begin
        cmd(frmc_cmd_t'(i), 3'h1, 1'b0, 1'b0);
        chk("grant", 0, gnt);
      end
    end
    @(posedge clk);
    lw <= 1'b1;
    lwd <= 8'hFF;
    @(posedge clk);
    lw <= 1'b0;
    #1;
    chk("lock", 8'hFF, lock);
    wr_cpu(1'b0, 1'b0);
  endtask : t_cmds

  task automatic t_area;
    area(20'h40000, 1'b1, 1'b1);
    area(20'h3FFFF, 1'b1, 1'b0);
    area(20'hBFFFF, 1'b1, 1'b1);
    area(20'hC0000, 1'b1, 1'b0);
    area(20'h40000, 1'b0, 1'b0);
    wr_cpu(1'b1, 1'b0);
    area(20'h80000, 1'b1, 1'b0);
    wr_cpu(1'b0, 1'b0);
  endtask : t_area

  task automatic t_parallel;
    do_reset(5'b00010);
    chk("mode", FRMC_MODE_PARALLEL, mode);
    cmd(FRMC_CMD_PROGRAM, 3'h3, 1'b0, 1'b1);
    chk("grant", 11'h408, gnt);
    cmd(FRMC_CMD_BLOCK_ERASE, 3'h0, 1'b1, 1'b0);
    chk("grant", 11'h400, gnt);
    wr_cpu(1'b1, 1'b0);
    chk("cpu_act", 0, cact);
  endtask : t_parallel

  task automatic t_restrict(input logic [4:0] s, input frmc_chip_t c);
    do_reset(s);
    chk("chip", c, chip);
    wr_cpu(1'b1, 1'b1);
    chk("cpu_act", 0, cact);
    wr_cpu(1'b1, 1'b0);
    chk("cpu_act", 1, cact);
    cmd(FRMC_CMD_PROGRAM, 3'h1, 1'b1, 1'b0);
    chk("grant", 2'b01, gnt[10:9]);
    wr_cpu(1'b0, 1'b0);
  endtask : t_restrict

  task automatic t_serial;
    @(posedge clk);
    s_att <= 1'b1;
    s_uart <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("mode", FRMC_MODE_SERIAL, mode);
    chk("variant2", 1, var2);
    cmd(FRMC_CMD_PROGRAM, 3'h1, 1'b0, 1'b1);
    chk("grant", 2'b01, gnt[10:9]);
    @(posedge clk);
    s_uart <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("variant2", 0, var2);
  endtask : t_serial

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    t_reset();
    t_cpu();
    t_cmds();
    t_area();
    t_parallel();
    t_restrict(5'b00001, FRMC_CHIP_EXPAND);
    t_restrict(5'b11000, FRMC_CHIP_BOOT);
    t_serial();
    complete_run();
  end

  // A hung sequence must still reach the verdict
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("ERROR watchdog expected done seen hang");
    complete_run();
  end
endmodule : frmc_top_test
